// *** idx_exec_unit.sv ***
// execution unit for multiply, indexed add, indexed bit set and indexed set-all
// assumes an APB master on core_clk; memory and core registers reached through APB
//
// How it works
// - multiply puts the unsigned product of accumulator and operand in the product pair, high byte upper.
// - multiply leaves the accumulator and the operand byte untouched.
// - multiply changes no status flag and does not flag a zero product.
// - access bit clear picks the access bank, set picks the bank chosen by the bank select register.
// - access bit clear, extended set on and file address up to 95 switch to indexed offset mode.
// - indexed add sums the accumulator and the byte at third pointer plus offset.
// - destination bit clear sends the sum to the accumulator, set sends it back to memory.
// - indexed bit set forces bit b of the addressed byte and keeps all else.
// - indexed set-all writes all ones to the addressed byte and keeps the flags.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module idx_exec_unit
  import idx_exec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [PDATA_W-1:0] pwdata,
  output logic [PDATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic {S_IDLE, S_EXEC} state_e;

  state_e state_reg;
  logic extEnable_reg;
  logic [ST_W-1:0] status_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [BANK_W-1:0] bank_select_reg;
  logic [ADDR_W-1:0] third_file_pointer_reg;
  logic [DATA_W-1:0] product_high_byte_reg;
  logic [DATA_W-1:0] product_low_byte_reg;
  logic [INSTR_W-1:0] instr_reg;
  logic [ADDR_W-1:0] memAddr_reg;
  logic [PDATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  logic accessTake;
  logic wrTake;
  logic rdTake;
  logic addrHit;
  logic [ADDR_W-1:0] effAddr;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] memRdApb;
  op_e op;
  logic execNow;

  // ****************************************
  // apb decode
  // ****************************************
  // one wait state: pready rises one cycle after the access phase starts
  assign accessTake = psel && penable && !pready_reg;
  // writes land at the edge where the master sees pready high, never one earlier
  assign wrTake = psel && penable && pready_reg && pwrite && addrHit;
  assign rdTake = accessTake && !pwrite;

  always_comb begin
    case (paddr)
      OFF_CTRL, OFF_STATUS, OFF_ACC, OFF_BANK, OFF_PTR, OFF_PRODUCT_HIGH_BYTE, OFF_PRODUCT_LOW_BYTE,
      OFF_INSTR, OFF_MEMADDR, OFF_MEMDATA: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= accessTake;
      pslverr_reg <= accessTake && !addrHit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_reg <= '0;
    end else if (rdTake) begin
      prdata_reg <= '0;
      case (paddr)
        OFF_CTRL: prdata_reg[CTRL_EXT_BIT] <= extEnable_reg;
        OFF_STATUS: begin
          prdata_reg[ST_W-1:0] <= status_reg;
          prdata_reg[ST_BUSY_BIT] <= (state_reg == S_EXEC);
        end
        OFF_ACC: prdata_reg[DATA_W-1:0] <= acc_reg;
        OFF_BANK: prdata_reg[BANK_W-1:0] <= bank_select_reg;
        OFF_PTR: prdata_reg[ADDR_W-1:0] <= third_file_pointer_reg;
        OFF_PRODUCT_HIGH_BYTE: prdata_reg[DATA_W-1:0] <= product_high_byte_reg;
        OFF_PRODUCT_LOW_BYTE: prdata_reg[DATA_W-1:0] <= product_low_byte_reg;
        OFF_INSTR: prdata_reg[INSTR_W-1:0] <= instr_reg;
        OFF_MEMADDR: prdata_reg[ADDR_W-1:0] <= memAddr_reg;
        OFF_MEMDATA: prdata_reg[DATA_W-1:0] <= memRdApb;
        default: prdata_reg <= '0;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // register write strobes
  // ****************************************
  logic wrCtrl;
  logic wrStatus;
  logic wrAcc;
  logic wrBank;
  logic wrPtr;
  logic wrProdHigh;
  logic wrProdLow;
  logic wrInstr;
  logic wrMemAddr;
  logic wrMemData;

  assign wrCtrl = wrTake && (paddr == OFF_CTRL);
  assign wrStatus = wrTake && (paddr == OFF_STATUS);
  assign wrAcc = wrTake && (paddr == OFF_ACC);
  assign wrBank = wrTake && (paddr == OFF_BANK);
  assign wrPtr = wrTake && (paddr == OFF_PTR);
  assign wrProdHigh = wrTake && (paddr == OFF_PRODUCT_HIGH_BYTE);
  assign wrProdLow = wrTake && (paddr == OFF_PRODUCT_LOW_BYTE);
  assign wrInstr = wrTake && (paddr == OFF_INSTR);
  assign wrMemAddr = wrTake && (paddr == OFF_MEMADDR);
  assign wrMemData = wrTake && (paddr == OFF_MEMDATA);

  // ****************************************
  // software-owned registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      extEnable_reg <= 1'b0;
      bank_select_reg <= BANK_RST;
      memAddr_reg <= PTR_RST;
    end else if (wrTake) begin
      if (wrCtrl) extEnable_reg <= pwdata[CTRL_EXT_BIT];
      if (wrBank) bank_select_reg <= pwdata[BANK_W-1:0];
      if (wrMemAddr) memAddr_reg <= pwdata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      third_file_pointer_reg <= PTR_RST;
    end else if (wrPtr) begin
      third_file_pointer_reg <= pwdata[ADDR_W-1:0];
    end
  end

  // ****************************************
  // instruction issue
  // ****************************************
  // a write to the instruction register issues it; execution takes the next cycle,
  // which always ends before the next apb access can complete
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instr_reg <= INSTR_RST;
      state_reg <= S_IDLE;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (wrInstr) begin
            instr_reg <= pwdata[INSTR_W-1:0];
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign execNow = (state_reg == S_EXEC);
  assign op = decodeOp(instr_reg);

  operand_addr operand_addr_i (
    .instr(instr_reg),
    .bankSel(bank_select_reg),
    .pointer(third_file_pointer_reg),
    .extEnable(extEnable_reg),
    .effAddr(effAddr),
    .indexed()
  );

  // ****************************************
  // datapath
  // ****************************************
  logic [DATA_W:0] sumFull;
  logic [DATA_W/2:0] sumLow;
  logic [2*DATA_W-1:0] product;
  logic [DATA_W-1:0] sum;
  logic [DATA_W-1:0] bitMask;
  logic addToMem;
  logic memWrEn;
  logic [ADDR_W-1:0] memWrAddr;
  logic [DATA_W-1:0] memWrData;

  assign sumFull = {1'b0, acc_reg} + {1'b0, operand};
  assign sumLow = {1'b0, acc_reg[DATA_W/2-1:0]} + {1'b0, operand[DATA_W/2-1:0]};
  assign sum = sumFull[DATA_W-1:0];
  assign product = acc_reg * operand;
  assign bitMask = DATA_W'(1) << instr_reg[B_LSB +: B_W];
  assign addToMem = instr_reg[D_BIT];

  always_comb begin
    memWrEn = 1'b0;
    memWrAddr = effAddr;
    memWrData = operand;
    if (execNow) begin
      case (op)
        OP_ADD: begin
          memWrEn = addToMem;
          memWrData = sum;
        end
        OP_BSET: begin
          memWrEn = 1'b1;
          memWrData = operand | bitMask;
        end
        OP_SET_FILE_ALL_ONES: begin
          memWrEn = 1'b1;
          memWrData = ALL_ONES;
        end
        default: memWrEn = 1'b0;
      endcase
    end else if (wrMemData) begin
      memWrEn = 1'b1;
      memWrAddr = memAddr_reg;
      memWrData = pwdata[DATA_W-1:0];
    end
  end

  data_store data_store_i (
    .core_clk(core_clk),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddrA(effAddr),
    .rdDataA(operand),
    .rdAddrB(memAddr_reg),
    .rdDataB(memRdApb)
  );

  // ****************************************
  // core register updates
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_reg <= ACC_RST;
    end else if (execNow) begin
      if (op == OP_ADD && !addToMem) acc_reg <= sum;
    end else if (wrAcc) begin
      acc_reg <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      product_high_byte_reg <= ACC_RST;
      product_low_byte_reg <= ACC_RST;
    end else if (execNow && op == OP_MUL) begin
      product_high_byte_reg <= product[2*DATA_W-1:DATA_W];
      product_low_byte_reg <= product[DATA_W-1:0];
    end else if (wrTake) begin
      if (wrProdHigh) product_high_byte_reg <= pwdata[DATA_W-1:0];
      if (wrProdLow) product_low_byte_reg <= pwdata[DATA_W-1:0];
    end
  end

  // only the add touches flags; multiply, bit set and set-all keep them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= STATUS_RST;
    end else if (execNow) begin
      if (op == OP_ADD) begin
        status_reg[ST_C] <= sumFull[DATA_W];
        status_reg[ST_DC] <= sumLow[DATA_W/2];
        status_reg[ST_Z] <= (sum == '0);
        status_reg[ST_N] <= sum[DATA_W-1];
        status_reg[ST_OV] <= (acc_reg[DATA_W-1] == operand[DATA_W-1])
                             && (sum[DATA_W-1] != acc_reg[DATA_W-1]);
      end
    end else if (wrStatus) begin
      status_reg <= pwdata[ST_W-1:0];
    end
  end

endmodule : idx_exec_unit

// *** idx_exec_pkg.sv ***
// constants, field layout and decode helpers for the indexed offset and multiply unit
// assumes one core clock domain and a 32-bit APB register port
package idx_exec_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int INSTR_W = 16;
  localparam int PADDR_W = 8;
  localparam int PDATA_W = 32;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_ACC = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_BANK = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_PTR = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_PRODUCT_HIGH_BYTE = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_PRODUCT_LOW_BYTE = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_INSTR = 8'h1C;
  localparam logic [PADDR_W-1:0] OFF_MEMADDR = 8'h20;
  localparam logic [PADDR_W-1:0] OFF_MEMDATA = 8'h24;

  // ****************************************
  // bit positions and reset values
  // ****************************************
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_W = 5;
  localparam int ST_BUSY_BIT = 8;
  localparam int BANK_W = 4;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [ST_W-1:0] STATUS_RST = 5'h00;
  localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

  // ****************************************
  // instruction fields
  // ****************************************
  localparam int F_MSB = 7;
  localparam int A_BIT = 8;
  localparam int D_BIT = 9;
  localparam int B_LSB = 9;
  localparam int B_W = 3;
  localparam logic [6:0] PAT_MUL = 7'h01;
  localparam logic [5:0] PAT_ADD = 6'h09;
  localparam logic [3:0] PAT_BSET = 4'h8;
  localparam logic [6:0] PAT_SET_FILE_ALL_ONES = 7'h34;
  localparam logic [DATA_W-1:0] INDEX_LIMIT = 8'h5F;
  localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;

  typedef enum logic [2:0] {OP_NONE, OP_MUL, OP_ADD, OP_BSET, OP_SET_FILE_ALL_ONES} op_e;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic op_e decodeOp(input logic [INSTR_W-1:0] ins);
    op_e r;
    r = OP_NONE;
    if (ins[15:9] == PAT_MUL) r = OP_MUL;
    else if (ins[15:10] == PAT_ADD) r = OP_ADD;
    else if (ins[15:12] == PAT_BSET) r = OP_BSET;
    else if (ins[15:9] == PAT_SET_FILE_ALL_ONES) r = OP_SET_FILE_ALL_ONES;
    return r;
  endfunction : decodeOp

  function automatic logic [DATA_W-1:0] fileField(input logic [INSTR_W-1:0] ins);
    return ins[F_MSB:0];
  endfunction : fileField

endpackage : idx_exec_pkg

// *** operand_addr.sv ***
// effective data address of the file operand of one instruction word
// assumes the pointer and bank inputs are stable core registers
`timescale 1ns/1ps
module operand_addr
  import idx_exec_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [BANK_W-1:0] bankSel,
  input wire logic [ADDR_W-1:0] pointer,
  input wire logic extEnable,
  output logic [ADDR_W-1:0] effAddr,
  output logic indexed
);

  logic [DATA_W-1:0] fileAddr;
  logic accessSel;

  assign fileAddr = fileField(instr);
  assign accessSel = instr[A_BIT];
  assign indexed = !accessSel && extEnable && (fileAddr <= INDEX_LIMIT);

  always_comb begin
    if (indexed) begin
      effAddr = pointer + {{(ADDR_W-DATA_W){1'b0}}, fileAddr};
    end else if (accessSel) begin
      effAddr = {bankSel, fileAddr};
    end else if (fileAddr < ACCESS_SPLIT) begin
      effAddr = {ACCESS_LOW_BANK, fileAddr};
    end else begin
      effAddr = {ACCESS_HIGH_BANK, fileAddr};
    end
  end

endmodule : operand_addr

// *** data_store.sv ***
// byte-wide data memory in flip-flops, one write port and two read ports
// assumes the caller never asks for two writes in one cycle
`timescale 1ns/1ps
module data_store
  import idx_exec_pkg::*;
(
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddrA,
  output logic [DATA_W-1:0] rdDataA,
  input wire logic [ADDR_W-1:0] rdAddrB,
  output logic [DATA_W-1:0] rdDataB
);

  // contents are not reset: software owns initialisation, like real ram
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule : data_store

// *** idx_exec_unit_properties.sv ***
// checker for the register port of the indexed offset and multiply unit
// assumes it is bound to idx_exec_unit and sees only its ports
`timescale 1ns/1ps
module idx_exec_unit_properties
  import idx_exec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [PDATA_W-1:0] pwdata,
  input wire logic [PDATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_take_rd;
    s_take ##0 !pwrite;
  endsequence

  property p_answer;
    s_take |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_err_pair;
    pslverr |-> pready;
  endproperty
  property p_in_access;
    pready |-> psel && penable;
  endproperty
  property p_unmapped;
    s_take ##0 (paddr > OFF_MEMDATA) |=> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_mapped;
    s_take ##0 (paddr <= OFF_MEMDATA) |=> !pslverr;
  endproperty
  // prdata only moves when a read is taken, so a late sample cannot see stale junk
  property p_hold;
    !(psel && penable && !pready && !pwrite) |=> $stable(prdata);
  endproperty
  property p_prod_byte;
    s_take_rd ##0 (paddr == OFF_PRODUCT_HIGH_BYTE || paddr == OFF_PRODUCT_LOW_BYTE) |=> prdata[31:8] == 24'h0;
  endproperty
  property p_status_bits;
    s_take_rd ##0 (paddr == OFF_STATUS) |=> prdata[31:9] == 23'h0;
  endproperty

  a_answer: assert property (p_answer) else $error("no answer after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err_pair: assert property (p_err_pair) else $error("error without ready");
  a_in_access: assert property (p_in_access) else $error("ready outside access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_prod_byte: assert property (p_prod_byte) else $error("product byte too wide");
  a_status_bits: assert property (p_status_bits) else $error("status upper bits set");
endmodule : idx_exec_unit_properties

bind idx_exec_unit idx_exec_unit_properties idx_exec_unit_properties_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** tb_idx_exec_unit.sv ***
// self-checking bench for the indexed offset and multiply unit
// assumes the unit answers every access with a one-cycle pready pulse
`timescale 1ns/1ps
module tb_idx_exec_unit;
  import idx_exec_pkg::*;
  `define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata, prdata, rdata;
  int n_errors = 0;
  int checked = 0;

  idx_exec_unit idx_exec_unit_i (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input string nm, input logic [PADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdata)
  endtask : rc

  task automatic mw(input logic [31:0] a, input logic [31:0] d);
    wr(OFF_MEMADDR, a);
    wr(OFF_MEMDATA, d);
  endtask : mw

  task automatic mc(input string nm, input logic [31:0] a, input logic [31:0] e);
    wr(OFF_MEMADDR, a);
    rc(nm, OFF_MEMDATA, e);
  endtask : mc

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rc("reset value", 8'(i * 4), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped data", 32'h0, rdata)
    `CHK("unmapped error", 1'b1, err)
    $display("test reset done");
  endtask : t_reset

  task automatic mul_case(input logic [31:0] acc, d, a, ins, p);
    wr(OFF_STATUS, 32'h15);
    wr(OFF_ACC, acc);
    mw(a, d);
    wr(OFF_INSTR, ins);
    rc("prod high", OFF_PRODUCT_HIGH_BYTE, {24'h0, p[15:8]});
    rc("prod low", OFF_PRODUCT_LOW_BYTE, {24'h0, p[7:0]});
    rc("mul acc", OFF_ACC, acc);
    mc("mul operand", a, d);
    rc("mul flags", OFF_STATUS, 32'h15);
  endtask : mul_case

  task automatic t_mul;
    wr(OFF_BANK, 32'h2);
    mul_case(32'hC4, 32'hB5, 32'h235, 32'h0335, 32'h8A94);
    mul_case(32'h00, 32'hB5, 32'h235, 32'h0335, 32'h0000);
    mul_case(32'h05, 32'h03, 32'h010, 32'h0210, 32'h000F);
    mul_case(32'hFF, 32'hFF, 32'hF80, 32'h0280, 32'hFE01);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_PTR, 32'hA00);
    mul_case(32'h02, 32'h21, 32'hA5F, 32'h025F, 32'h0042);
    mul_case(32'h02, 32'h30, 32'hF60, 32'h0260, 32'h0060);
    $display("test multiply done");
  endtask : t_mul

  task automatic t_add;
    mw(32'hA2C, 32'h20);
    wr(OFF_ACC, 32'h17);
    wr(OFF_INSTR, 32'h242C);
    rc("add to acc", OFF_ACC, 32'h37);
    mc("add mem kept", 32'hA2C, 32'h20);
    wr(OFF_INSTR, 32'h262C);
    mc("add to mem", 32'hA2C, 32'h57);
    rc("acc kept", OFF_ACC, 32'h37);
    rc("pointer kept", OFF_PTR, 32'hA00);
    $display("test add done");
  endtask : t_add

  task automatic t_bits;
    wr(OFF_PTR, 32'hFFF);
    for (int b = 0; b < 8; b++) begin
      mw(32'h009, 32'h55);
      wr(OFF_STATUS, 32'h1F);
      wr(OFF_INSTR, 32'h800A | (b << 9));
      mc("bit set", 32'h009, 32'h55 | (32'h1 << b));
      rc("bit flags", OFF_STATUS, 32'h1F);
    end
    mw(32'h05E, 32'h0);
    wr(OFF_INSTR, 32'h685F);
    mc("set all", 32'h05E, 32'hFF);
    rc("set flags", OFF_STATUS, 32'h1F);
    rc("wrap pointer", OFF_PTR, 32'hFFF);
    $display("test bits done");
  endtask : t_bits

  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_mul();
    t_add();
    t_bits();
    final_report();
  end

  // a few hundred accesses at most; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
endmodule : tb_idx_exec_unit
